// ### l1cc_cfg.svh
`ifndef L1CC_CFG_SVH
`define L1CC_CFG_SVH
`define L1CC_RST_ENABLE      1'b0
`define L1CC_RST_FLAG        1'b0
`define L1CC_ATTR_WT_BIT     4
`define L1CC_ATTR_CI_BIT     3
`define L1CC_ATTR_M_BIT      2
`define L1CC_ATTR_WIDTH      5
`define L1CC_CLEAR_NS        100
`define L1CC_CLK_NS          100
`define L1CC_CLEAR_CYC       ((`L1CC_CLEAR_NS + `L1CC_CLK_NS - 1) / `L1CC_CLK_NS)
`endif

// ### l1cc_ctl.sv
`timescale 1ns/1ps
`default_nettype none
`include "l1cc_cfg.svh"
module l1cc_ctl
  import l1cc_pkg::*;
(
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire logic                        clk_en,
  input  wire logic                        wr_data_cache_enable,
  input  wire logic                        wr_instr_cache_enable,
  input  wire logic                        set_data_flash_invalidate,
  input  wire logic                        set_instr_flash_invalidate,
  input  wire logic                        set_data_lock_flash_clear,
  input  wire logic                        set_instr_lock_flash_clear,
  input  wire logic                        clr_data_overlock_flag,
  input  wire logic                        clr_instr_overlock_flag,
  input  wire logic                        write_shadow_mode,
  input  wire logic                        data_parity_err,
  input  wire logic                        instr_parity_err,
  input  wire logic                        data_access_busy,
  input  wire logic                        instr_access_busy,
  input  wire logic                        data_req,
  input  wire logic                        data_req_cacheable,
  input  wire logic                        fetch_req,
  input  wire logic                        fetch_req_cacheable,
  input  wire logic                        snoop_req,
  input  wire logic                        op_valid,
  input  wire logic                        op_is_instr,
  input  wire l1cc_op_t                    op_kind,
  input  wire logic [`L1CC_ATTR_WIDTH-1:0] page_attribute_bits,
  input  wire logic                        op_set_full_locked,
  input  wire logic                        op_modified_fill,
  input  wire logic                        op_xlate_fault,
  input  wire logic                        user_state_flag,
  input  wire logic                        guest_state_flag,
  input  wire logic                        user_lock_enable,
  input  wire logic                        user_lock_protect,
  output logic                             data_cache_enable,
  output logic                             instr_cache_enable,
  output logic                             data_flash_invalidate,
  output logic                             instr_flash_invalidate,
  output logic                             data_lock_flash_clear,
  output logic                             instr_lock_flash_clear,
  output logic                             data_overlock_flag,
  output logic                             instr_overlock_flag,
  output logic                             data_valid_clear,
  output logic                             instr_valid_clear,
  output logic                             data_lock_clear,
  output logic                             instr_lock_clear,
  output logic                             data_array_access,
  output logic                             data_bypass_req,
  output logic                             instr_array_access,
  output logic                             instr_bypass_req,
  output logic                             fill_buf_active,
  output logic                             instr_burst_req,
  output logic                             snoop_lookup,
  output logic                             op_to_cache,
  output logic                             op_mem_zero,
  output logic                             op_push_first,
  output logic                             op_line_place,
  output logic                             op_to_write_buffer,
  output logic                             data_storage_exc,
  output logic                             hv_priv_exc,
  output logic                             xlate_exc,
  output logic                             data_lock_syndrome,
  output logic                             instr_lock_syndrome
);

  logic data_cache_enable_ff;
  logic instr_cache_enable_ff;
  logic dfi_ff;
  logic ifi_ff;
  logic dlfc_ff;
  logic ilfc_ff;
  logic dolk_ff;
  logic iolk_ff;
  logic dvc_ff;
  logic ivc_ff;
  logic dlc_ff;
  logic ilc_ff;
  logic nxt_dvc;
  logic nxt_ivc;
  logic nxt_dlc;
  logic nxt_ilc;
  logic d_idle;
  logic i_idle;
  logic is_lock_op;
  logic op_cache_en;
  logic set_dolk;
  logic set_iolk;
  l1cc_lock_res_t lock_res;

  ////////////////////////////////////////////////////////////////////////
  // Enables and flash operations
  assign d_idle = !data_access_busy;
  assign i_idle = !instr_access_busy;

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      data_cache_enable_ff  <= `L1CC_RST_ENABLE;
      instr_cache_enable_ff <= `L1CC_RST_ENABLE;
    end
    else if (clk_en)
    begin
      if (d_idle)
        data_cache_enable_ff <= wr_data_cache_enable;
      if (i_idle)
        instr_cache_enable_ff <= wr_instr_cache_enable;
    end
  end

  // Invalidate request held until the array is idle, then one clear pulse
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      dfi_ff <= `L1CC_RST_FLAG;
      ifi_ff <= `L1CC_RST_FLAG;
    end
    else if (clk_en)
    begin
      if (set_data_flash_invalidate || (write_shadow_mode && data_parity_err))
        dfi_ff <= 1'b1;
      else if (dvc_ff)
        dfi_ff <= 1'b0;
      if (set_instr_flash_invalidate || instr_parity_err)
        ifi_ff <= 1'b1;
      else if (ivc_ff)
        ifi_ff <= 1'b0;
    end
  end

  always_comb
  begin
    nxt_dvc = dfi_ff && !dvc_ff && d_idle;
    nxt_ivc = ifi_ff && !ivc_ff && i_idle;
    nxt_dlc = dlfc_ff || nxt_dvc;
    nxt_ilc = ilfc_ff || nxt_ivc;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      dvc_ff <= 1'b1;
      ivc_ff <= 1'b1;
      dlc_ff <= 1'b1;
      ilc_ff <= 1'b1;
    end
    else if (clk_en)
    begin
      dvc_ff <= nxt_dvc;
      ivc_ff <= nxt_ivc;
      dlc_ff <= nxt_dlc;
      ilc_ff <= nxt_ilc;
    end
  end

  // Lock flash clear lasts exactly one cycle
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      dlfc_ff <= `L1CC_RST_FLAG;
      ilfc_ff <= `L1CC_RST_FLAG;
    end
    else if (clk_en)
    begin
      dlfc_ff <= set_data_lock_flash_clear && !dlfc_ff;
      ilfc_ff <= set_instr_lock_flash_clear && !ilfc_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Cache operation decode
  assign is_lock_op  = (op_kind == L1CC_OP_LOCK_SET) || (op_kind == L1CC_OP_LOCK_CLR);
  assign op_cache_en = op_is_instr ? instr_cache_enable_ff : data_cache_enable_ff;

  always_comb
  begin
    if (user_state_flag && !user_lock_enable)
      lock_res = L1CC_LK_DSI;
    else if (!user_state_flag && guest_state_flag && user_lock_protect)
      lock_res = L1CC_LK_HVPRIV;
    else
      lock_res = L1CC_LK_EXEC;
  end

  assign set_dolk = op_valid && !op_is_instr && is_lock_op && !op_xlate_fault
                    && lock_res == L1CC_LK_EXEC && op_cache_en && op_set_full_locked
                    && op_kind == L1CC_OP_LOCK_SET;
  assign set_iolk = op_valid && op_is_instr && is_lock_op && !op_xlate_fault
                    && lock_res == L1CC_LK_EXEC && op_cache_en && op_set_full_locked
                    && op_kind == L1CC_OP_LOCK_SET;

  // Overlock flags: set wins over clear
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      dolk_ff <= `L1CC_RST_FLAG;
      iolk_ff <= `L1CC_RST_FLAG;
    end
    else if (clk_en)
    begin
      dolk_ff <= set_dolk || (dolk_ff && !clr_data_overlock_flag);
      iolk_ff <= set_iolk || (iolk_ff && !clr_instr_overlock_flag);
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      op_to_cache         <= 1'b0;
      op_mem_zero         <= 1'b0;
      op_push_first       <= 1'b0;
      op_line_place       <= 1'b0;
      op_to_write_buffer  <= 1'b0;
      data_storage_exc    <= 1'b0;
      hv_priv_exc         <= 1'b0;
      xlate_exc           <= 1'b0;
      data_lock_syndrome  <= 1'b0;
      instr_lock_syndrome <= 1'b0;
    end
    else if (clk_en)
    begin
      xlate_exc        <= op_valid && is_lock_op && op_xlate_fault;
      data_storage_exc <= op_valid && is_lock_op && !op_xlate_fault && lock_res == L1CC_LK_DSI;
      hv_priv_exc      <= op_valid && is_lock_op && !op_xlate_fault && lock_res == L1CC_LK_HVPRIV;
      data_lock_syndrome  <= op_valid && is_lock_op && !op_xlate_fault && !op_is_instr
                             && lock_res == L1CC_LK_DSI;
      instr_lock_syndrome <= op_valid && is_lock_op && !op_xlate_fault && op_is_instr
                             && lock_res == L1CC_LK_DSI;
      op_to_cache   <= op_valid && op_kind != L1CC_OP_NONE && op_cache_en
                       && !(is_lock_op && (op_xlate_fault || lock_res != L1CC_LK_EXEC));
      op_mem_zero   <= op_valid && !op_is_instr && op_kind == L1CC_OP_BLK_ZERO
                       && !data_cache_enable_ff;
      op_push_first <= op_valid && !op_is_instr && op_kind == L1CC_OP_BLK_INVAL && data_cache_enable_ff
                       && page_attribute_bits[`L1CC_ATTR_M_BIT]
                       && !page_attribute_bits[`L1CC_ATTR_CI_BIT];
      op_line_place <= op_valid && op_kind == L1CC_OP_LOCK_SET && op_cache_en && !op_set_full_locked
                       && !op_xlate_fault && lock_res == L1CC_LK_EXEC;
      op_to_write_buffer <= op_valid && op_modified_fill && op_set_full_locked
                            && !is_lock_op && data_cache_enable_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Access routing
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      data_array_access  <= 1'b0;
      data_bypass_req    <= 1'b0;
      instr_array_access <= 1'b0;
      instr_bypass_req   <= 1'b0;
      instr_burst_req    <= 1'b0;
      snoop_lookup       <= 1'b0;
      fill_buf_active    <= 1'b0;
    end
    else if (clk_en)
    begin
      data_array_access  <= data_req && data_req_cacheable && data_cache_enable_ff;
      data_bypass_req    <= data_req && data_req_cacheable && !data_cache_enable_ff;
      instr_array_access <= fetch_req && fetch_req_cacheable && instr_cache_enable_ff;
      instr_bypass_req   <= fetch_req && fetch_req_cacheable && !instr_cache_enable_ff;
      instr_burst_req    <= fetch_req && fetch_req_cacheable;
      snoop_lookup       <= snoop_req && data_cache_enable_ff;
      fill_buf_active    <= 1'b1;
    end
  end

  assign data_cache_enable      = data_cache_enable_ff;
  assign instr_cache_enable     = instr_cache_enable_ff;
  assign data_flash_invalidate  = dfi_ff;
  assign instr_flash_invalidate = ifi_ff;
  assign data_lock_flash_clear  = dlfc_ff;
  assign instr_lock_flash_clear = ilfc_ff;
  assign data_overlock_flag     = dolk_ff;
  assign instr_overlock_flag    = iolk_ff;
  assign data_valid_clear       = dvc_ff;
  assign instr_valid_clear      = ivc_ff;
  assign data_lock_clear        = dlc_ff;
  assign instr_lock_clear       = ilc_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  chk_reset_enables_off: assert property (@(posedge core_clk)
    $past(rst) |-> !data_cache_enable && !instr_cache_enable)
    else $error("cache enable not cleared by reset");
  chk_disabled_no_lookup: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && !data_cache_enable) |=> !data_array_access)
    else $error("disabled data cache accessed");
  chk_bypass_route: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && data_req && data_req_cacheable && !data_cache_enable) |=> data_bypass_req)
    else $error("bypass not issued");
  chk_no_snoop_off: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && !data_cache_enable) |=> !snoop_lookup)
    else $error("snoop while disabled");
  chk_dfi_clears: assert property (@(posedge core_clk) disable iff (rst)
    (data_valid_clear && clk_en && !set_data_flash_invalidate && !(write_shadow_mode && data_parity_err))
    |=> !data_flash_invalidate)
    else $error("flash invalidate did not self clear");
  chk_ipar_inval: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && instr_parity_err) |=> instr_flash_invalidate)
    else $error("icache parity did not invalidate");
  chk_inval_locks: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && data_valid_clear) |-> data_lock_clear)
    else $error("invalidate kept locks");
  chk_lfc_pulse: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && data_lock_flash_clear) |=> !data_lock_flash_clear)
    else $error("lock clear longer than one cycle");
  chk_user_lock_dsi: assert property (@(posedge core_clk) disable iff (rst)
    (clk_en && op_valid && op_kind == L1CC_OP_LOCK_SET && !op_xlate_fault && user_state_flag && !user_lock_enable)
    |=> data_storage_exc && !op_line_place)
    else $error("user lock not refused");

endmodule // l1cc_ctl
`default_nettype wire

// ### l1cc_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module l1cc_far_model
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       data_bypass_req,
  input  wire logic       instr_burst_req,
  output logic      [7:0] bypass_seen,
  output logic      [7:0] burst_seen
);
  // Memory side takes bypass reads as cacheable traffic and line bursts
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      bypass_seen <= 8'h00;
      burst_seen  <= 8'h00;
    end
    else
    begin
      bypass_seen <= bypass_seen + {7'h00, data_bypass_req};
      burst_seen  <= burst_seen + {7'h00, instr_burst_req};
    end
  end
endmodule // l1cc_far_model
`default_nettype wire

// ### l1cc_pkg.sv
package l1cc_pkg;
  typedef enum logic [1:0] {
    L1CC_LK_EXEC,
    L1CC_LK_DSI,
    L1CC_LK_HVPRIV
  } l1cc_lock_res_t;
  typedef enum logic [2:0] {
    L1CC_OP_NONE,
    L1CC_OP_TOUCH,
    L1CC_OP_LOCK_SET,
    L1CC_OP_LOCK_CLR,
    L1CC_OP_BLK_ZERO,
    L1CC_OP_BLK_INVAL,
    L1CC_OP_OTHER
  } l1cc_op_t;
endpackage

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
`define L1CC_CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module tb
  import l1cc_pkg::*;
;
  typedef struct packed {
    logic en, ins; l1cc_op_t kind; logic [4:0] attr;
    logic full, md, xf, usr, gst, ule, ulp;
    logic [7:0] exp;
  } l1cc_row_t;
  logic core_clk, rst, clk_en, wr_data_cache_enable, wr_instr_cache_enable;
  logic set_data_flash_invalidate, set_instr_flash_invalidate, set_data_lock_flash_clear;
  logic set_instr_lock_flash_clear, clr_data_overlock_flag, clr_instr_overlock_flag;
  logic write_shadow_mode, data_parity_err, instr_parity_err, data_access_busy, instr_access_busy;
  logic data_req, data_req_cacheable, fetch_req, fetch_req_cacheable, snoop_req, op_valid, op_is_instr;
  l1cc_op_t op_kind;
  logic [4:0] page_attribute_bits;
  logic op_set_full_locked, op_modified_fill, op_xlate_fault, user_state_flag, guest_state_flag;
  logic user_lock_enable, user_lock_protect, data_cache_enable, instr_cache_enable;
  logic data_flash_invalidate, instr_flash_invalidate, data_lock_flash_clear, instr_lock_flash_clear;
  logic data_overlock_flag, instr_overlock_flag, data_valid_clear, instr_valid_clear;
  logic data_lock_clear, instr_lock_clear, data_array_access, data_bypass_req, instr_array_access;
  logic instr_bypass_req, fill_buf_active, instr_burst_req, snoop_lookup, op_to_cache, op_mem_zero;
  logic op_push_first, op_line_place, op_to_write_buffer, data_storage_exc, hv_priv_exc, xlate_exc;
  logic data_lock_syndrome, instr_lock_syndrome;
  logic [7:0] bypass_seen, burst_seen;
  int fail_count, n_tests, cycles, k;
  // Expected: dsi hv xlate dsyn isyn zero push wbuf
  l1cc_row_t rows [13] = '{
    '{1, 0, L1CC_OP_LOCK_SET, 5'h00, 0, 0, 0, 1, 0, 0, 0, 8'h90},
    '{1, 1, L1CC_OP_LOCK_SET, 5'h00, 0, 0, 0, 1, 0, 0, 0, 8'h88},
    '{1, 0, L1CC_OP_LOCK_CLR, 5'h00, 0, 0, 0, 1, 0, 1, 0, 8'h00},
    '{1, 0, L1CC_OP_LOCK_SET, 5'h00, 0, 0, 0, 0, 1, 0, 1, 8'h40},
    '{1, 1, L1CC_OP_LOCK_CLR, 5'h00, 0, 0, 0, 0, 1, 0, 0, 8'h00},
    '{1, 0, L1CC_OP_LOCK_SET, 5'h00, 0, 0, 0, 0, 0, 0, 1, 8'h00},
    '{1, 0, L1CC_OP_LOCK_SET, 5'h00, 0, 0, 1, 1, 0, 0, 0, 8'h20},
    '{0, 0, L1CC_OP_BLK_ZERO, 5'h00, 0, 0, 0, 0, 0, 0, 0, 8'h04},
    '{1, 0, L1CC_OP_BLK_INVAL, 5'h04, 0, 0, 0, 0, 0, 0, 0, 8'h02},
    '{1, 0, L1CC_OP_BLK_INVAL, 5'h00, 0, 0, 0, 0, 0, 0, 0, 8'h00},
    '{0, 0, L1CC_OP_TOUCH, 5'h00, 0, 0, 0, 0, 0, 0, 0, 8'h00},
    '{1, 0, L1CC_OP_TOUCH, 5'h00, 1, 1, 0, 0, 0, 0, 0, 8'h01},
    '{1, 0, L1CC_OP_LOCK_SET, 5'h00, 1, 0, 0, 0, 0, 0, 0, 8'h00}};

  l1cc_ctl dut (.*);
  l1cc_far_model far (.*);

  always #50 core_clk = ~core_clk;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic set_en(input logic d, input logic i);
    @(posedge core_clk);
    wr_data_cache_enable <= d;
    wr_instr_cache_enable <= i;
    @(posedge core_clk);
  endtask

  task automatic run_row(input l1cc_row_t r);
    set_en(r.en, r.en);
    @(posedge core_clk);
    op_valid <= 1'b1;
    op_kind <= r.kind;
    {op_is_instr, page_attribute_bits, op_set_full_locked, op_modified_fill, op_xlate_fault, user_state_flag,
     guest_state_flag, user_lock_enable, user_lock_protect} <= {r.ins, r.attr, r.full, r.md, r.xf, r.usr,
     r.gst, r.ule, r.ulp};
    @(posedge core_clk);
    op_valid <= 1'b0;
    @(negedge core_clk);
    `L1CC_CHK("op result", r.exp, {data_storage_exc, hv_priv_exc, xlate_exc, data_lock_syndrome,
      instr_lock_syndrome, op_mem_zero, op_push_first, op_to_write_buffer})
    if (!r.en)
      `L1CC_CHK("op to cache", 1'b0, op_to_cache)
  endtask

  task automatic req(input logic d, input logic f, input logic s);
    @(posedge core_clk);
    {data_req, data_req_cacheable, fetch_req, fetch_req_cacheable, snoop_req} <= {d, d, f, f, s};
    @(posedge core_clk);
    {data_req, data_req_cacheable, fetch_req, fetch_req_cacheable, snoop_req} <= 5'h00;
    @(negedge core_clk);
  endtask

  initial
  begin
    {core_clk, clk_en, rst} = 3'b011;
    {wr_data_cache_enable, wr_instr_cache_enable, set_data_flash_invalidate, set_instr_flash_invalidate} = '0;
    {set_data_lock_flash_clear, set_instr_lock_flash_clear, clr_data_overlock_flag, clr_instr_overlock_flag} = '0;
    {write_shadow_mode, data_parity_err, instr_parity_err, data_access_busy, instr_access_busy} = '0;
    {data_req, data_req_cacheable, fetch_req, fetch_req_cacheable, snoop_req, op_valid, op_is_instr} = '0;
    op_kind = L1CC_OP_NONE;
    {page_attribute_bits, op_set_full_locked, op_modified_fill, op_xlate_fault, user_state_flag} = '0;
    {guest_state_flag, user_lock_enable, user_lock_protect, fail_count, n_tests, cycles} = '0;
    @(negedge core_clk);
    `L1CC_CHK("reset wipe", 4'hF, {data_valid_clear, instr_valid_clear, data_lock_clear,
      instr_lock_clear})
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    `L1CC_CHK("reset enables", 4'h0, {data_cache_enable, instr_cache_enable, data_overlock_flag,
      instr_overlock_flag})
    // Invalidate, poll, then enable both caches
    @(posedge core_clk);
    {set_data_flash_invalidate, set_instr_flash_invalidate} <= 2'b11;
    @(posedge core_clk);
    {set_data_flash_invalidate, set_instr_flash_invalidate} <= 2'b00;
    @(negedge core_clk);
    for (k = 0; k < 20 && (data_flash_invalidate !== 1'b0 || instr_flash_invalidate !== 1'b0); k++)
      @(negedge core_clk);
    `L1CC_CHK("poll done", 2'b00, {data_flash_invalidate, instr_flash_invalidate})
    set_en(1'b1, 1'b1);
    @(negedge core_clk);
    `L1CC_CHK("enables on", 2'b11, {data_cache_enable, instr_cache_enable})
    foreach (rows[i])
      run_row(rows[i]);
    `L1CC_CHK("overlock sticky", 2'b10, {data_overlock_flag, instr_overlock_flag})
    @(posedge core_clk);
    clr_data_overlock_flag <= 1'b1;
    @(posedge core_clk);
    clr_data_overlock_flag <= 1'b0;
    @(negedge core_clk);
    `L1CC_CHK("overlock clear", 1'b0, data_overlock_flag)
    // Overlock set beats a same-cycle clear, then a free set places the line
    @(posedge core_clk);
    {op_valid, op_is_instr, clr_instr_overlock_flag} <= 3'b111;
    @(posedge core_clk);
    {op_is_instr, clr_instr_overlock_flag, op_set_full_locked} <= 3'b000;
    @(negedge core_clk);
    `L1CC_CHK("overlock set wins", 2'b10, {instr_overlock_flag, op_line_place})
    @(posedge core_clk);
    op_valid <= 1'b0;
    @(negedge core_clk);
    `L1CC_CHK("line placed", 3'b110, {op_line_place, op_to_cache, data_overlock_flag})
    set_en(1'b0, 1'b0);
    req(1'b1, 1'b1, 1'b1);
    `L1CC_CHK("data bypass", 3'b101, {data_bypass_req, data_array_access, fill_buf_active})
    `L1CC_CHK("fetch bypass", 3'b110, {instr_bypass_req, instr_burst_req, instr_array_access})
    `L1CC_CHK("snoop off", 1'b0, snoop_lookup)
    set_en(1'b1, 1'b1);
    req(1'b1, 1'b0, 1'b1);
    `L1CC_CHK("data cached", 3'b011, {data_bypass_req, data_array_access, snoop_lookup})
    `L1CC_CHK("far counts", 16'h0101, {bypass_seen, burst_seen})
    @(posedge core_clk);
    data_access_busy <= 1'b1;
    wr_data_cache_enable <= 1'b0;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
    `L1CC_CHK("enable held", 1'b1, data_cache_enable)
    @(posedge core_clk);
    data_access_busy <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
    `L1CC_CHK("enable applied", 1'b0, data_cache_enable)
    @(posedge core_clk);
    set_data_flash_invalidate <= 1'b1;
    @(posedge core_clk);
    set_data_flash_invalidate <= 1'b0;
    @(negedge core_clk);
    `L1CC_CHK("dfi busy", 1'b1, data_flash_invalidate)
    @(negedge core_clk);
    `L1CC_CHK("dfi wipe", 3'b110, {data_valid_clear, data_lock_clear, instr_valid_clear})
    @(negedge core_clk);
    `L1CC_CHK("dfi done", 1'b0, data_flash_invalidate)
    @(posedge core_clk);
    {instr_parity_err, data_parity_err} <= 2'b11;
    @(posedge core_clk);
    {instr_parity_err, data_parity_err} <= 2'b00;
    @(negedge core_clk);
    `L1CC_CHK("parity auto", 2'b10, {instr_flash_invalidate, data_flash_invalidate})
    repeat (4) @(posedge core_clk);
    write_shadow_mode <= 1'b1;
    data_parity_err <= 1'b1;
    @(posedge core_clk);
    data_parity_err <= 1'b0;
    @(negedge core_clk);
    `L1CC_CHK("shadow parity", 1'b1, data_flash_invalidate)
    repeat (4) @(posedge core_clk);
    set_instr_lock_flash_clear <= 1'b1;
    @(posedge core_clk);
    set_instr_lock_flash_clear <= 1'b0;
    @(negedge core_clk);
    `L1CC_CHK("lfc set", 1'b1, instr_lock_flash_clear)
    @(negedge core_clk);
    `L1CC_CHK("lfc clear", 3'b100, {instr_lock_clear, instr_lock_flash_clear, data_lock_clear})
    // Clock enable low freezes requests and flags
    @(posedge core_clk);
    {clk_en, set_data_flash_invalidate, set_data_lock_flash_clear} <= 3'b011;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    `L1CC_CHK("frozen", 3'b001, {data_flash_invalidate, data_lock_flash_clear, instr_overlock_flag})
    @(posedge core_clk);
    {clk_en, set_data_flash_invalidate} <= 2'b10;
    @(posedge core_clk);
    set_data_lock_flash_clear <= 1'b0;
    @(negedge core_clk);
    `L1CC_CHK("data lfc", 2'b10, {data_lock_flash_clear, data_flash_invalidate})
    repeat (2) @(posedge core_clk);
    rst <= 1'b1;
    @(posedge core_clk);
    rst <= 1'b0;
    @(negedge core_clk);
    `L1CC_CHK("second reset", 4'h3, {data_cache_enable, instr_cache_enable, data_valid_clear,
      instr_lock_clear})
    tally_and_finish();
  end
endmodule // tb
`undef L1CC_CHK
`default_nettype wire
